/* File: verilog/bit_carry_ops_and_branch_eval.sv */
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
// Behaviour
// - Bit OR: carry becomes carry OR selected operand bit.
// - Inverted bit OR: carry becomes carry OR complement of selected bit.
// - Bit XOR: carry becomes carry XOR selected bit.
// - Inverted bit XOR: carry becomes carry XOR complement of selected bit.
// - Bit load: carry takes the selected bit.
// - Inverted bit load: carry takes complement of selected bit.
// - Bit store: carry written into selected bit, other bits kept.
// - Inverted bit store: complement of carry written into selected bit.
// - Inverted variants take bit position only from the 3-bit immediate.
// - Signed and always/never branch conditions from N, V, Z.
// - Unsigned branch conditions from C and Z.
// - Single-flag branch conditions on Z, V, N.
// - Jump always goes to the target, no flag tested.
// - Calls go to target; a later return resumes after the call.
// - Plain bit ops take position from immediate or register low bits.
// - Store forms read whole byte, change one bit, write byte back.
module bit_carry_ops_and_branch_eval
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  // APB answer
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core side status
  output logic             carry_out,
  output logic             branch_taken,
  output logic      [31:0] pc_out
);

  // Software visible state
  logic [12:0] ctrl_ff;
  logic [7:0]  opnd_ff;
  logic [31:0] target_ff;
  logic [3:0]  ccr_ff;
  logic [7:0]  result_ff;
  logic [31:0] pc_ff;
  logic [31:0] ret_pc_ff;
  logic [bitbr_pkg::STACK_AW-1:0] sp_ff;
  logic        taken_ff;
  logic        busy_ff;
  logic        ret_pend_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  // Bus decode
  wire setup_w   = psel & ~penable;
  wire access_w  = psel & penable & pready_ff;
  wire wr_w      = access_w & pwrite;
  wire hit_ctrl  = (paddr == bitbr_pkg::CTRL_OFS);
  wire hit_opnd  = (paddr == bitbr_pkg::OPND_OFS);
  wire hit_tgt   = (paddr == bitbr_pkg::TARGET_OFS);
  wire hit_ccr   = (paddr == bitbr_pkg::CCR_OFS);
  wire hit_res   = (paddr == bitbr_pkg::RESULT_OFS);
  wire hit_pc    = (paddr == bitbr_pkg::PC_OFS);
  wire hit_ret   = (paddr == bitbr_pkg::RETPC_OFS);
  wire hit_sp    = (paddr == bitbr_pkg::SP_OFS);
  wire hit_stat  = (paddr == bitbr_pkg::STATUS_OFS);
  wire hit_any   = hit_ctrl | hit_opnd | hit_tgt | hit_ccr | hit_res
                 | hit_pc | hit_ret | hit_sp | hit_stat;

  // Operation fields
  bitbr_pkg::op_t op_w;
  assign op_w = bitbr_pkg::op_t'(ctrl_ff[bitbr_pkg::CTRL_OP_LSB +: 5]);
  wire [2:0] imm_pos_w = ctrl_ff[bitbr_pkg::CTRL_IMM_LSB +: 3];
  wire [2:0] reg_pos_w = ctrl_ff[bitbr_pkg::CTRL_REG_LSB +: 3];
  wire       inv_op_w  = (op_w == bitbr_pkg::bit_inv_or_carry)
                       | (op_w == bitbr_pkg::bit_inv_xor_carry)
                       | (op_w == bitbr_pkg::bit_inv_load_carry)
                       | (op_w == bitbr_pkg::bit_inv_store_carry);

  // Bit position select
  // immediate only for inverted
  wire [2:0] pos_w = (ctrl_ff[bitbr_pkg::CTRL_USEREG] & ~inv_op_w) ? reg_pos_w : imm_pos_w;

  wire sel_bit_w = opnd_ff[pos_w];
  wire c_w = ccr_ff[bitbr_pkg::CCR_C];
  wire v_w = ccr_ff[bitbr_pkg::CCR_V];
  wire z_w = ccr_ff[bitbr_pkg::CCR_Z];
  wire n_w = ccr_ff[bitbr_pkg::CCR_N];
  wire nv_w = n_w ^ v_w;

  // Carry result of bit ops
  logic nxt_c;
  logic is_bitc;
  always_comb
  begin
    nxt_c   = c_w;
    is_bitc = 1'b1;
    case (op_w)
      bitbr_pkg::bit_or_carry:       nxt_c = c_w | sel_bit_w;
      bitbr_pkg::bit_inv_or_carry:   nxt_c = c_w | ~sel_bit_w;
      bitbr_pkg::bit_xor_carry:      nxt_c = c_w ^ sel_bit_w;
      bitbr_pkg::bit_inv_xor_carry:  nxt_c = c_w ^ ~sel_bit_w;
      bitbr_pkg::bit_load_carry:     nxt_c = sel_bit_w;
      bitbr_pkg::bit_inv_load_carry: nxt_c = ~sel_bit_w;
      default:                       is_bitc = 1'b0;
    endcase
  end

  // Store forms: one bit replaced, byte written back whole
  // carry into bit
  wire       is_store_w  = (op_w == bitbr_pkg::bit_store_carry)
                         | (op_w == bitbr_pkg::bit_inv_store_carry);
  wire       store_val_w = (op_w == bitbr_pkg::bit_inv_store_carry) ? ~c_w : c_w;
  wire [7:0] bit_mask_w  = 8'h01 << pos_w;
  wire [7:0] stored_w    = (opnd_ff & ~bit_mask_w) | (store_val_w ? bit_mask_w : 8'h00);

  // Branch condition
  logic cond;
  logic is_branch;
  always_comb
  begin
    cond      = 1'b0;
    is_branch = 1'b1;
    case (op_w)
      bitbr_pkg::branch_always:      cond = 1'b1;
      bitbr_pkg::branch_never:       cond = 1'b0;
      bitbr_pkg::branch_signed_ge:   cond = ~nv_w;
      bitbr_pkg::branch_signed_lt:   cond = nv_w;
      bitbr_pkg::branch_signed_gt:   cond = ~(z_w | nv_w);
      bitbr_pkg::branch_signed_le:   cond = z_w | nv_w;
      bitbr_pkg::branch_higher:      cond = ~(c_w | z_w);
      bitbr_pkg::branch_lower_same:  cond = c_w | z_w;
      bitbr_pkg::branch_carry_clear: cond = ~c_w;
      bitbr_pkg::branch_carry_set:   cond = c_w;
      bitbr_pkg::branch_not_equal:   cond = ~z_w;
      bitbr_pkg::branch_equal:       cond = z_w;
      bitbr_pkg::branch_ovf_clear:   cond = ~v_w;
      bitbr_pkg::branch_ovf_set:     cond = v_w;
      bitbr_pkg::branch_plus:        cond = ~n_w;
      bitbr_pkg::branch_minus:       cond = n_w;
      bitbr_pkg::jump_unconditional: cond = 1'b1;
      default:                       is_branch = 1'b0;
    endcase
  end

  // Calls and returns
  wire is_call_w = (op_w == bitbr_pkg::call_relative) | (op_w == bitbr_pkg::call_absolute);
  wire is_ret_w  = (op_w == bitbr_pkg::subr_return);
  wire [31:0] seq_pc_w  = pc_ff + bitbr_pkg::RET_STEP;
  // Relative call adds the target as a displacement to the next address
  wire [31:0] call_tgt_w = (op_w == bitbr_pkg::call_relative) ? seq_pc_w + target_ff
                                                                : target_ff;
  wire [31:0] br_tgt_w   = (op_w == bitbr_pkg::jump_unconditional) ? target_ff
                                                                   : seq_pc_w + target_ff;
  wire [bitbr_pkg::STACK_AW-1:0] sp_dec_w = sp_ff - 1'b1;
  wire [31:0] stack_rd_w;

  // Return stack: push on call, pop on return
  // resume after the call
  ret_stack_mem u_stack
  (
    .pclk    (pclk),
    .wr_en   (busy_ff & is_call_w),
    .wr_addr (sp_ff),
    .wr_data (seq_pc_w),
    .rd_addr (sp_dec_w),
    .rd_data (stack_rd_w)
  );

  // Write to CTRL with go bit starts one operation next cycle
  wire go_w = wr_w & hit_ctrl & pwdata[bitbr_pkg::CTRL_GO_POS];

  // Read mux
  wire [31:0] rd_mux_w =
      hit_ctrl ? {19'h0, ctrl_ff}                  :
      hit_opnd ? {24'h0, opnd_ff}                  :
      hit_tgt  ? target_ff                         :
      hit_ccr  ? {28'h0, ccr_ff}                   :
      hit_res  ? {24'h0, result_ff}                :
      hit_pc   ? pc_ff                             :
      hit_ret  ? ret_pc_ff                         :
      hit_sp   ? {28'h0, sp_ff}                    :
      hit_stat ? {30'h0, taken_ff, busy_ff | ret_pend_ff} :
                 32'h0000_0000;

  // APB slave: no wait states, ready in the first access cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup_w;
      prdata_ff  <= setup_w ? rd_mux_w : 32'h0000_0000;
      pslverr_ff <= setup_w & ~hit_any;
    end
  end

  // Register writes and execution
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff     <= 13'h0000;
      opnd_ff     <= 8'h00;
      target_ff   <= 32'h0000_0000;
      ccr_ff      <= bitbr_pkg::CCR_RST;
      result_ff   <= 8'h00;
      pc_ff       <= bitbr_pkg::PC_RST;
      ret_pc_ff   <= 32'h0000_0000;
      sp_ff       <= '0;
      taken_ff    <= 1'b0;
      busy_ff     <= 1'b0;
      ret_pend_ff <= 1'b0;
    end
    else
    begin
      busy_ff     <= go_w;
      ret_pend_ff <= busy_ff & is_ret_w;
      if (wr_w & hit_ctrl)
      begin
        ctrl_ff <= {pwdata[12:1], 1'b0};
      end
      if (wr_w & hit_opnd)
      begin
        opnd_ff <= pwdata[7:0];
      end
      if (wr_w & hit_tgt)
      begin
        target_ff <= pwdata;
      end
      if (wr_w & hit_ccr)
      begin
        ccr_ff <= pwdata[3:0];
      end
      if (wr_w & hit_pc)
      begin
        pc_ff <= pwdata;
      end
      if (busy_ff)
      begin
        result_ff <= is_store_w ? stored_w : opnd_ff;
        if (is_store_w)
        begin
          opnd_ff <= stored_w;
        end
        if (is_bitc)
        begin
          ccr_ff[bitbr_pkg::CCR_C] <= nxt_c;
        end
        taken_ff <= (is_branch & cond) | is_call_w | is_ret_w;
        if (is_branch)
        begin
          pc_ff <= cond ? br_tgt_w : seq_pc_w;
        end
        else if (is_call_w)
        begin
          pc_ff     <= call_tgt_w;
          ret_pc_ff <= seq_pc_w;
          sp_ff     <= sp_ff + 1'b1;
        end
        else if (is_ret_w)
        begin
          sp_ff <= sp_dec_w;
        end
        else
        begin
          pc_ff <= seq_pc_w;
        end
      end
      if (ret_pend_ff)
      begin
        pc_ff <= stack_rd_w;
      end
    end
  end

  // Core side outputs registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      carry_out    <= 1'b0;
      branch_taken <= 1'b0;
      pc_out       <= bitbr_pkg::PC_RST;
    end
    else
    begin
      carry_out    <= ccr_ff[bitbr_pkg::CCR_C];
      branch_taken <= taken_ff;
      pc_out       <= pc_ff;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

endmodule // bit_carry_ops_and_branch_eval

/* File: verilog/bitbr_pkg.sv */
package bitbr_pkg;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] OPND_OFS    = 12'h004;
  localparam logic [11:0] TARGET_OFS  = 12'h008;
  localparam logic [11:0] CCR_OFS     = 12'h00C;
  localparam logic [11:0] RESULT_OFS  = 12'h010;
  localparam logic [11:0] PC_OFS      = 12'h014;
  localparam logic [11:0] RETPC_OFS   = 12'h018;
  localparam logic [11:0] SP_OFS      = 12'h01C;
  localparam logic [11:0] STATUS_OFS  = 12'h020;

  // CTRL fields: go[0], op[5:1], imm bit[8:6], use_reg[9], reg bits[12:10]
  localparam int CTRL_GO_POS    = 0;
  localparam int CTRL_OP_LSB    = 1;
  localparam int CTRL_IMM_LSB   = 6;
  localparam int CTRL_USEREG    = 9;
  localparam int CTRL_REG_LSB   = 10;

  // CCR layout: C[0] V[1] Z[2] N[3]
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;

  localparam logic [3:0]  CCR_RST    = 4'h0;
  localparam logic [31:0] PC_RST     = 32'h0000_0000;
  localparam logic [31:0] SP_RST     = 32'h0000_0100;
  localparam logic [31:0] RET_STEP   = 32'h0000_0002;
  localparam logic [3:0]  STACK_DEPTH_LOG = 4'h4;
  localparam int          STACK_AW   = 4;

  typedef enum logic [4:0] {
    OP_NONE            = 5'h00,
    bit_or_carry       = 5'h01,
    bit_inv_or_carry   = 5'h02,
    bit_xor_carry      = 5'h03,
    bit_inv_xor_carry  = 5'h04,
    bit_load_carry     = 5'h05,
    bit_inv_load_carry = 5'h06,
    bit_store_carry    = 5'h07,
    bit_inv_store_carry= 5'h08,
    branch_always      = 5'h09,
    branch_never       = 5'h0A,
    branch_higher      = 5'h0B,
    branch_lower_same  = 5'h0C,
    branch_carry_clear = 5'h0D,
    branch_carry_set   = 5'h0E,
    branch_not_equal   = 5'h0F,
    branch_equal       = 5'h10,
    branch_ovf_clear   = 5'h11,
    branch_ovf_set     = 5'h12,
    branch_plus        = 5'h13,
    branch_minus       = 5'h14,
    branch_signed_ge   = 5'h15,
    branch_signed_lt   = 5'h16,
    branch_signed_gt   = 5'h17,
    branch_signed_le   = 5'h18,
    jump_unconditional = 5'h19,
    call_relative      = 5'h1A,
    call_absolute      = 5'h1B,
    subr_return        = 5'h1C
  } op_t;

endpackage

/* File: verilog/ret_stack_mem.sv */
`timescale 1ns/10ps
// Return address memory, registered read port
module ret_stack_mem
(
  // Clock
  input  wire logic                        pclk,
  // Write port
  input  wire logic                        wr_en,
  input  wire logic [bitbr_pkg::STACK_AW-1:0] wr_addr,
  input  wire logic [31:0]                 wr_data,
  // Read port
  input  wire logic [bitbr_pkg::STACK_AW-1:0] rd_addr,
  output logic      [31:0]                 rd_data
);

  logic [31:0] mem [0:(1<<bitbr_pkg::STACK_AW)-1];

  always_ff @(posedge pclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // ret_stack_mem

/* File: bench/bitbr_monitor.sv */
`timescale 1ns/10ps
module bitbr_monitor
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus request
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Bus answer and core status
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        carry_out,
  input wire logic        branch_taken,
  input wire logic [31:0] pc_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s; psel && !penable; endsequence
  sequence wr_s; psel && penable && pready && pwrite; endsequence
  sequence go_s; wr_s ##0 paddr == bitbr_pkg::CTRL_OFS && pwdata[0]; endsequence

  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  unmapped_err_a: assert property (setup_s ##0 paddr > bitbr_pkg::STATUS_OFS |=> pslverr)
    else $error("unmapped access not refused");
  carry_follow_a: assert property (wr_s ##0 paddr == bitbr_pkg::CCR_OFS |->
    ##2 carry_out == $past(pwdata[0], 2)) else $error("carry_out does not follow flags");
  pc_follow_a: assert property (wr_s ##0 paddr == bitbr_pkg::PC_OFS |->
    ##2 pc_out == $past(pwdata, 2)) else $error("pc_out does not follow pc");
  never_taken_a: assert property (go_s ##0 pwdata[5:1] == bitbr_pkg::branch_never |->
    ##3 !branch_taken) else $error("never form was taken");
  always_taken_a: assert property (go_s ##0 pwdata[5:1] == bitbr_pkg::branch_always |->
    ##3 branch_taken) else $error("always form not taken");
endmodule // bitbr_monitor

bind bit_carry_ops_and_branch_eval bitbr_monitor mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .carry_out, .branch_taken, .pc_out);

/* File: bench/bit_carry_ops_and_branch_eval_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end \
  end
module bit_carry_ops_and_branch_eval_bench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        carry_out;
  logic        branch_taken;
  logic [31:0] pc_out;
  integer      seed, fails, n_checks, i, k;
  logic [31:0] rd, pc, tg, pe;
  logic [8:0]  ex;
  logic [7:0]  v;
  logic [3:0]  fl;
  logic [4:0]  op;
  logic [2:0]  pos, rpos;
  logic        ur, ef, tk;

  bit_carry_ops_and_branch_eval uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .carry_out, .branch_taken, .pc_out);

  always #20 pclk = ~pclk;

  task end_sim;
    begin
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // Releases one edge before the next setup, so no signal is driven twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer t;
    begin
      t = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && t < 20)
      begin
        t++;
        @(posedge pclk);
      end
      if (t >= 20)
      begin
        fails++;
        end_sim;
      end
      rd = prdata;
      ef = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic run(input logic [31:0] ctrl);
    integer t;
    begin
      t = 0;
      apb(1'b1, bitbr_pkg::CTRL_OFS, ctrl);
      rd = 32'h1;
      while (rd[0] !== 1'b0 && t < 50)
      begin
        apb(1'b0, bitbr_pkg::STATUS_OFS, 32'h0);
        t++;
      end
      if (t >= 50)
      begin
        fails++;
        end_sim;
      end
    end
  endtask

  function automatic logic [8:0] bit_exp(input logic [4:0] o, input logic [7:0] b,
                                         input logic cy, input logic [2:0] p);
    logic s;
    s = b[p];
    case (o)
      5'h01: return {cy | s, b};
      5'h02: return {cy | ~s, b};
      5'h03: return {cy ^ s, b};
      5'h04: return {cy ^ ~s, b};
      5'h05: return {s, b};
      5'h06: return {~s, b};
      default:
      begin
        b[p] = (o == 5'h07) ? cy : ~cy;
        return {cy, b};
      end
    endcase
  endfunction

  // Each even code is the complement of the odd code before it
  function automatic logic br_exp(input logic [4:0] o, input logic [3:0] f);
    logic [7:0] t;
    t = ~{f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
    return t[(o - 5'h09) >> 1] ^ ~o[0];
  endfunction

  initial
  begin
    seed = 43;
    fails = 0;
    n_checks = 0;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, bitbr_pkg::PC_OFS, 32'h0);
    `CHK("pc_rst", bitbr_pkg::PC_RST, rd)
    apb(1'b1, 12'h030, 32'hFFFF_FFFF);
    `CHK("wr_err", 1'b1, ef)
    apb(1'b0, 12'h024, 32'h0);
    `CHK("rd_err", ({1'b1, 32'h0}), ({ef, rd}))
    for (i = 0; i < 64; i++)
    begin
      op = 5'h01 + 5'(i % 8);
      v = 8'($random(seed));
      fl = 4'($random(seed));
      pos = (i < 16) ? {3{i[3]}} : 3'($random(seed));
      rpos = 3'($random(seed));
      ur = 1'($random(seed));
      ex = bit_exp(op, v, fl[0], (ur && op[0]) ? rpos : pos);
      apb(1'b1, bitbr_pkg::CCR_OFS, {28'h0, fl});
      apb(1'b1, bitbr_pkg::OPND_OFS, {24'h0, v});
      run({19'h0, rpos, ur, pos, op, 1'b1});
      apb(1'b0, bitbr_pkg::CCR_OFS, 32'h0);
      `CHK("carry", ex[8], rd[0])
      apb(1'b0, bitbr_pkg::OPND_OFS, 32'h0);
      `CHK("opnd", ({24'h0, ex[7:0]}), rd)
      apb(1'b0, bitbr_pkg::RESULT_OFS, 32'h0);
      `CHK("result", ({24'h0, ex[7:0]}), rd)
      `CHK("carry_out", ex[8], carry_out)
    end
    for (i = 0; i < 80; i++)
    begin
      op = 5'h09 + 5'(i % 16);
      fl = 4'($random(seed));
      pc = $random(seed) & 32'hFFFF_FFFE;
      tg = $random(seed) & 32'hFFFF_FFFE;
      tk = br_exp(op, fl);
      apb(1'b1, bitbr_pkg::CCR_OFS, {28'h0, fl});
      apb(1'b1, bitbr_pkg::PC_OFS, pc);
      apb(1'b1, bitbr_pkg::TARGET_OFS, tg);
      run({26'h0, op, 1'b1});
      apb(1'b0, bitbr_pkg::STATUS_OFS, 32'h0);
      `CHK("taken", tk, rd[1])
      `CHK("branch_taken", tk, branch_taken)
      apb(1'b0, bitbr_pkg::PC_OFS, 32'h0);
      `CHK("br_pc", tk ? pc + 32'h2 + tg : pc + 32'h2, rd)
    end
    for (k = 0; k < 6; k++)
    begin
      op = 5'h19 + 5'(k % 3);
      pc = $random(seed) & 32'hFFFF_FFFE;
      tg = $random(seed) & 32'hFFFF_FFFE;
      pe = (op == 5'h1A) ? pc + 32'h2 + tg : tg;
      apb(1'b1, bitbr_pkg::CCR_OFS, {28'h0, 4'($random(seed))});
      apb(1'b1, bitbr_pkg::PC_OFS, pc);
      apb(1'b1, bitbr_pkg::TARGET_OFS, tg);
      run({26'h0, op, 1'b1});
      apb(1'b0, bitbr_pkg::PC_OFS, 32'h0);
      `CHK("jump_pc", pe, rd)
      `CHK("jump_taken", 1'b1, branch_taken)
      if (op != 5'h19)
      begin
        run({26'h0, 5'h1C, 1'b1});
        apb(1'b0, bitbr_pkg::PC_OFS, 32'h0);
        `CHK("ret_pc", pc + 32'h2, rd)
        `CHK("pc_out", pc + 32'h2, pc_out)
      end
    end
    // Mid-run reset must bring flags and pc back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("pc_out_rst", bitbr_pkg::PC_RST, pc_out)
    `CHK("carry_out_rst", bitbr_pkg::CCR_RST[0], carry_out)
    apb(1'b0, bitbr_pkg::CCR_OFS, 32'h0);
    `CHK("ccr_rst", ({28'h0, bitbr_pkg::CCR_RST}), rd)
    apb(1'b0, bitbr_pkg::PC_OFS, 32'h0);
    `CHK("pc_rst2", bitbr_pkg::PC_RST, rd)
    end_sim;
  end
endmodule // bit_carry_ops_and_branch_eval_bench
